// >>> rtl/srp_pkg.sv
// Purpose: shared constants and types for the serial register port
// Assumes: host is an spi-style master timing every transfer with its serial clock
// Notes:   register storage lives outside; this port only moves words to and from it
package srp_pkg;
	localparam int INSTR_BITS   = 16;
	localparam int DATA_BITS    = 8;
	localparam int ADDR_BITS    = 15;
	localparam int RW_POS       = 15;
	localparam int CNT_BITS     = 5;
	localparam int SCLK_MAX_MHZ = 10;
	localparam logic [2:0] TOG_INIT = 3'h0;

	typedef struct packed {
		logic                 lsb_order_select;
		logic                 addr_increment;
		logic                 out_pin_active;
	} srp_cfg_type;

	typedef struct packed {
		logic [ADDR_BITS-1:0] addr;
		logic [DATA_BITS-1:0] data;
	} srp_word_type;
endpackage

// >>> rtl/srp_sync.sv
// Purpose: two-flop level synchroniser
// Assumes: input is a level from another clock domain
// Notes:   first flop is read only by the second
`timescale 1ns/1ps
module srp_sync #(
	parameter int WIDTH = 1
) (
	input  wire logic             clk,
	input  wire logic             rst_b,
	input  wire logic [WIDTH-1:0] d,
	output logic      [WIDTH-1:0] q
);
	logic [WIDTH-1:0] meta_ff;

	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_ff <= '0;
			q       <= '0;
		end else begin
			meta_ff <= d;
			q       <= meta_ff;
		end
	end
endmodule

// >>> rtl/srp_port.sv
// Purpose: serial register port, link side on sclk, register side on ref_clk
// Assumes: host keeps chip select low for a whole transfer, sclk at or below 10 MHz
// Notes:   one write or read request per byte crosses by toggle; read data must be
//          answered well within half an sclk cycle (ref_clk much faster than sclk)
//
// Function
// - first 16 rising sclk edges after chip select falls carry the instruction
// - chip select high then low restarts at the instruction phase
// - data phase moves whole bytes of eight sclk cycles each
// - a write byte updates its register right after its last bit
// - instruction top bit one means read, zero means write
// - lower fifteen instruction bits give the starting register address
// - address increment set: address rises by one after each byte
// - address increment clear: address falls by one after each byte
// - both msb-first and lsb-first wire orders are supported
// - four-wire with separate pins or three-wire on a shared pin
// - inputs sampled on rising sclk, outputs launched on falling sclk
// - shared pin released while chip select is high
// - lsb-first: address from bit zero, then rw flag, then data from bit zero
// - output pin active: read data on separate pin, else on shared pin
`timescale 1ns/1ps
module srp_port
	import srp_pkg::*;
(
	input  wire logic                      ref_clk,
	input  wire logic                      rst_b,
	input  wire logic                      sclk,
	input  wire logic                      cs_b,
	input  wire logic                      sdio_in,
	output logic                           sdio_out,
	output logic                           sdio_oe,
	output logic                           serial_data_out,
	input  wire srp_pkg::srp_cfg_type      cfg,
	output srp_pkg::srp_word_type          wr_word,
	output logic                           wr_strobe,
	output logic [srp_pkg::ADDR_BITS-1:0]  rd_addr,
	output logic                           rd_strobe,
	input  wire logic [srp_pkg::DATA_BITS-1:0] rd_data
);
	import srp_pkg::*;

	// ----------------------------------------------------------------
	// link side, sclk domain
	// ----------------------------------------------------------------
	// chip select works as async reset of the link logic, so a frame
	// always starts clean even though sclk stops between frames
	logic                    link_rst_b;
	logic [CNT_BITS-1:0]     bit_cnt_ff;
	logic [INSTR_BITS-1:0]   instr_ff;
	logic                    in_data_ff;
	logic                    is_read_ff;
	logic [ADDR_BITS-1:0]    addr_ff;
	logic [DATA_BITS-1:0]    shift_ff;
	logic [2:0]              dbit_ff;
	logic                    wr_tog_ff;
	logic                    rd_tog_ff;
	srp_word_type            wr_hold_ff;
	logic [ADDR_BITS-1:0]    rd_req_addr_ff;
	logic [DATA_BITS-1:0]    tx_ff;
	logic                    tx_bit_ff;
	logic                    drive_ff;

	logic [INSTR_BITS-1:0]   nxt_instr;
	logic [DATA_BITS-1:0]    nxt_shift;
	logic                    instr_last;
	logic                    byte_last;
	logic [ADDR_BITS-1:0]    instr_addr;
	logic                    instr_rw;

	assign link_rst_b = rst_b & ~cs_b;

	function automatic logic [ADDR_BITS-1:0] step_addr(input logic [ADDR_BITS-1:0] a, input logic inc);
		step_addr = inc ? ADDR_BITS'(a + 1'b1) : ADDR_BITS'(a - 1'b1);
	endfunction

	function automatic logic [DATA_BITS-1:0] rev8(input logic [DATA_BITS-1:0] v);
		for (int i = 0; i < DATA_BITS; i++) begin
			rev8[i] = v[DATA_BITS-1-i];
		end
	endfunction

	assign nxt_instr  = {instr_ff[INSTR_BITS-2:0], sdio_in};
	assign nxt_shift  = {shift_ff[DATA_BITS-2:0], sdio_in};
	assign instr_last = !in_data_ff && (bit_cnt_ff == CNT_BITS'(INSTR_BITS-1));
	assign byte_last  = in_data_ff && (dbit_ff == 3'h7);

	// msb-first: rw, a14..a0; lsb-first: a0..a14, rw
	always_comb begin
		if (cfg.lsb_order_select) begin
			instr_rw = nxt_instr[0];
			for (int i = 0; i < ADDR_BITS; i++) begin
				instr_addr[i] = nxt_instr[INSTR_BITS-1-i];
			end
		end else begin
			instr_rw   = nxt_instr[RW_POS];
			instr_addr = nxt_instr[ADDR_BITS-1:0];
		end
	end

	always_ff @(posedge sclk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			bit_cnt_ff <= '0;
			instr_ff   <= '0;
			in_data_ff <= 1'b0;
			is_read_ff <= 1'b0;
			dbit_ff    <= 3'h0;
			shift_ff   <= '0;
		end else begin
			if (!in_data_ff) begin
				instr_ff   <= nxt_instr;
				bit_cnt_ff <= CNT_BITS'(bit_cnt_ff + 1'b1);
				if (instr_last) begin
					in_data_ff <= 1'b1;
					is_read_ff <= instr_rw;
				end
			end else begin
				shift_ff <= nxt_shift;
				dbit_ff  <= 3'(dbit_ff + 1'b1);
			end
		end
	end

	// address survives cs so the crossed copy stays valid; it is reloaded each frame
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			addr_ff <= '0;
		end else if (!cs_b) begin
			if (instr_last) begin
				addr_ff <= instr_addr;
			end else if (byte_last) begin
				addr_ff <= step_addr(addr_ff, cfg.addr_increment);
			end
		end
	end

	// requests are held past cs release so the other domain can still take them
	always_ff @(posedge sclk or negedge rst_b) begin
		if (!rst_b) begin
			wr_tog_ff      <= 1'b0;
			rd_tog_ff      <= 1'b0;
			wr_hold_ff     <= '0;
			rd_req_addr_ff <= '0;
		end else if (!cs_b) begin
			if (byte_last && !is_read_ff) begin
				wr_hold_ff.addr <= addr_ff;
				wr_hold_ff.data <= cfg.lsb_order_select ? rev8(nxt_shift) : nxt_shift;
				wr_tog_ff       <= ~wr_tog_ff;
			end
			// fetch each read byte on the last rising sclk edge before it starts
			if (instr_last && instr_rw) begin
				rd_req_addr_ff <= instr_addr;
				rd_tog_ff      <= ~rd_tog_ff;
			end else if (byte_last && is_read_ff) begin
				rd_req_addr_ff <= step_addr(addr_ff, cfg.addr_increment);
				rd_tog_ff      <= ~rd_tog_ff;
			end
		end
	end

	// ----------------------------------------------------------------
	// read data launch on falling sclk
	// ----------------------------------------------------------------
	logic [DATA_BITS-1:0] rd_data_ff;
	logic [DATA_BITS-1:0] rd_data_link;
	logic [DATA_BITS-1:0] rd_ordered;

	assign rd_ordered = cfg.lsb_order_select ? rev8(rd_data_link) : rd_data_link;

	always_ff @(negedge sclk or negedge link_rst_b) begin
		if (!link_rst_b) begin
			tx_ff     <= '0;
			tx_bit_ff <= 1'b0;
			drive_ff  <= 1'b0;
		end else begin
			drive_ff <= in_data_ff && is_read_ff;
			if (in_data_ff && is_read_ff) begin
				if (dbit_ff == 3'h0) begin
					tx_bit_ff <= rd_ordered[DATA_BITS-1];
					tx_ff     <= {rd_ordered[DATA_BITS-2:0], 1'b0};
				end else begin
					tx_bit_ff <= tx_ff[DATA_BITS-1];
					tx_ff     <= {tx_ff[DATA_BITS-2:0], 1'b0};
				end
			end
		end
	end

	assign serial_data_out = cfg.out_pin_active ? tx_bit_ff : 1'b0;
	assign sdio_out        = tx_bit_ff;
	assign sdio_oe         = drive_ff && !cfg.out_pin_active && !cs_b;

	// ----------------------------------------------------------------
	// register side, ref_clk domain
	// ----------------------------------------------------------------
	logic       wr_tog_sync;
	logic       rd_tog_sync;
	// one seen bit per toggle: bit 0 write, bit 1 read
	logic [1:0] tog_seen_ff;

	srp_sync #(.WIDTH(2)) u_tog_sync (
		.clk   (ref_clk),
		.rst_b (rst_b),
		.d     ({wr_tog_ff, rd_tog_ff}),
		.q     ({wr_tog_sync, rd_tog_sync})
	);

	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			tog_seen_ff <= TOG_INIT[1:0];
			wr_strobe   <= 1'b0;
			rd_strobe   <= 1'b0;
			wr_word     <= '0;
			rd_addr     <= '0;
		end else begin
			tog_seen_ff[0] <= wr_tog_sync;
			tog_seen_ff[1] <= rd_tog_sync;
			wr_strobe      <= wr_tog_sync ^ tog_seen_ff[0];
			rd_strobe      <= rd_tog_sync ^ tog_seen_ff[1];
			// held words are stable for many ref_clk cycles around each toggle
			if (wr_tog_sync ^ tog_seen_ff[0]) begin
				wr_word <= wr_hold_ff;
			end
			if (rd_tog_sync ^ tog_seen_ff[1]) begin
				rd_addr <= rd_req_addr_ff;
			end
		end
	end

	// answer captured the cycle after the strobe, stable until the next fetch
	always_ff @(posedge ref_clk or negedge rst_b) begin
		if (!rst_b) begin
			rd_data_ff <= '0;
		end else if (rd_strobe) begin
			rd_data_ff <= rd_data;
		end
	end

	// quasi-static word: changes only between sclk falling edges that use it
	assign rd_data_link = rd_data_ff;
endmodule

// >>> testbench/srp_port_asserts.sv
// Purpose: port checks for the serial register port
// Assumes: all checks sampled on ref_clk
// Notes:   sclk side seen only through its effects
`timescale 1ns/1ps
module srp_port_asserts (
	input wire logic                          ref_clk,
	input wire logic                          rst_b,
	input wire logic                          cs_b,
	input wire logic                          sdio_oe,
	input wire logic                          serial_data_out,
	input wire srp_pkg::srp_cfg_type          cfg,
	input wire srp_pkg::srp_word_type         wr_word,
	input wire logic                          wr_strobe,
	input wire logic [srp_pkg::ADDR_BITS-1:0] rd_addr,
	input wire logic                          rd_strobe
);
	import srp_pkg::*;
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_b);
	property p_wr_pulse; $rose(wr_strobe) |=> $fell(wr_strobe); endproperty
	a_wr_pulse: assert property (p_wr_pulse) else $error("write strobe too long");
	property p_rd_pulse; rd_strobe |=> !rd_strobe; endproperty
	a_rd_pulse: assert property (p_rd_pulse) else $error("read strobe too long");
	property p_one_dir; !(wr_strobe && rd_strobe); endproperty
	a_one_dir: assert property (p_one_dir) else $error("read and write together");
	property p_oe_cs; cs_b |-> !sdio_oe; endproperty
	a_oe_cs: assert property (p_oe_cs) else $error("shared pin driven while deselected");
	property p_sdo_off; !cfg.out_pin_active |-> !serial_data_out; endproperty
	a_sdo_off: assert property (p_sdo_off) else $error("unused output pin toggles");
	property p_oe_4w; cfg.out_pin_active |-> !sdio_oe; endproperty
	a_oe_4w: assert property (p_oe_4w) else $error("shared pin driven in four-wire");
	property p_word_hold; $changed(wr_word) |-> wr_strobe; endproperty
	a_word_hold: assert property (p_word_hold) else $error("write word moved alone");
	property p_addr_hold; $changed(rd_addr) |-> rd_strobe; endproperty
	a_addr_hold: assert property (p_addr_hold) else $error("read address moved alone");
endmodule

// >>> testbench/srp_host.sv
// Purpose: host master model driving framed transfers
// Assumes: sclk idles low and stands still between frames
// Notes:   released data line toggles so stale bits never pass
`timescale 1ns/1ps
module srp_host (
	output logic                     sclk,
	output logic                     cs_b,
	output logic                     sdio_in,
	input wire logic                 sdio_out,
	input wire logic                 sdio_oe,
	input wire logic                 serial_data_out,
	input wire srp_pkg::srp_cfg_type cfg
);
	import srp_pkg::*;
	logic drv = 1'b1;
	initial begin
		sclk = 1'b0;
		cs_b = 1'b1;
	end
	assign sdio_in = sdio_oe ? sdio_out : drv;
	task automatic frame(input logic rd, input logic [14:0] a, input int n, input int lim, input int hp,
		input logic [31:0] wd, output logic [31:0] rv);
		logic [15:0] w;
		int          j;
		logic        s;
		w = {rd, a};
		rv = '0;
		cs_b = 1'b0;
		#hp;
		for (int t = 0; t < 16 + 8 * n && t < lim; t++) begin
			j = t < 16 ? t : (t - 16) % 8;
			if (!cfg.lsb_order_select) j = (t < 16 ? 15 : 7) - j;
			if (t >= 16) j = j + 8 * ((t - 16) / 8);
			drv = t < 16 ? w[j] : rd ? ~drv : wd[j];
			#hp;
			sclk = 1'b1;
			s = cfg.out_pin_active ? serial_data_out : sdio_in;
			#hp;
			sclk = 1'b0;
			if (t >= 16) rv[j] = s;
		end
		#hp;
		cs_b = 1'b1;
		drv = ~drv;
		#160;
	endtask
endmodule

// >>> testbench/srp_port_tb.sv
// Purpose: self-checking bench for the serial register port
// Assumes: register file answers combinationally
// Notes:   reads run a slow sclk, prefetch needs ref_clk margin
`timescale 1ns/1ps
module srp_port_tb;
	import srp_pkg::*;
	logic                 ref_clk = 1'b0;
	logic                 rst_b = 1'b0;
	logic                 sclk, cs_b, sdio_in, sdio_out, sdio_oe, serial_data_out, wr_strobe, rd_strobe;
	srp_cfg_type          cfg = '0;
	srp_word_type         wr_word;
	srp_word_type         wq[$];
	logic [ADDR_BITS-1:0] rd_addr, a;
	logic [7:0]           rd_data;
	int                   n_fail = 0, checked = 0;
	int                   seed = 32'h3f0385a4;
	always #20 ref_clk = ~ref_clk;
	function automatic logic [7:0] reg_val(input logic [14:0] x);
		return x[7:0] ^ {1'b0, x[14:8]};
	endfunction
	function automatic logic [14:0] step(input logic [14:0] x, input int k);
		return cfg.addr_increment ? x + 15'(k) : x - 15'(k);
	endfunction
	assign rd_data = reg_val(rd_addr);
	srp_port DUT (.ref_clk, .rst_b, .sclk, .cs_b, .sdio_in, .sdio_out, .sdio_oe, .serial_data_out, .cfg,
		.wr_word, .wr_strobe, .rd_addr, .rd_strobe, .rd_data);
	srp_host host (.sclk, .cs_b, .sdio_in, .sdio_out, .sdio_oe, .serial_data_out, .cfg);
	always @(posedge ref_clk) if (wr_strobe) wq.push_back(wr_word);
	// ----------------------------------------
	// checks
	// ----------------------------------------
	task automatic chk_word(input srp_word_type e, input srp_word_type g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH wr_word exp %h got %h", e, g);
		end
	endtask
	task automatic chk_byte(input string nm, input logic [7:0] e, input logic [7:0] g);
		checked++;
		if (g !== e) begin
			n_fail++;
			$display("MISMATCH %s exp %h got %h", nm, e, g);
		end
	endtask
	task automatic end_sim;
		$display("checked %0d n_fail %0d", checked, n_fail);
		if (n_fail == 0 && checked > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask
	task automatic do_write(input logic [14:0] x, input int n, input int lim, input int nexp);
		logic [31:0] wd, rv;
		wd = $random(seed);
		wq.delete();
		host.frame(1'b0, x, n, lim, 16, wd, rv);
		for (int w = 0; w < 20 && wq.size() < nexp; w++) @(posedge ref_clk);
		chk_byte("writes", 8'(nexp), 8'(wq.size()));
		if (wq.size() < nexp) end_sim;
		for (int k = 0; k < nexp; k++) chk_word({step(x, k), wd[8*k +: 8]}, wq[k]);
	endtask
	task automatic do_read(input logic [14:0] x);
		logic [31:0] rv;
		host.frame(1'b1, x, 3, 99, 200, 32'h0, rv);
		for (int k = 0; k < 3; k++) chk_byte("rd_byte", reg_val(step(x, k)), rv[8*k +: 8]);
	endtask
	initial begin
		repeat (8) @(posedge ref_clk);
		@(negedge ref_clk) rst_b = 1'b1;
		repeat (3) @(posedge ref_clk);
		for (int it = 0; it < 8; it++) begin
			@(negedge ref_clk) cfg = srp_cfg_type'(it[2:0]);
			a = it == 0 ? 15'h0 : it == 2 ? 15'h7fff : 15'($random(seed));
			do_write(a, 1 + it % 3, 99, 1 + it % 3);
			do_read(a);
		end
		do_write(15'h10, 2, 27, 1);
		do_write(15'h10, 1, 21, 0);
		do_write(15'h20, 1, 99, 1);
		end_sim;
	end
endmodule
bind srp_port srp_port_asserts u_chk (.ref_clk, .rst_b, .cs_b, .sdio_oe, .serial_data_out, .cfg, .wr_word,
	.wr_strobe, .rd_addr, .rd_strobe);
